//--- rtl/qps_pkg.sv
package qps_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_SAVE   = 8'h00;
  localparam logic [7:0] OFF_MOTOR  = 8'h04;
  localparam logic [7:0] OFF_CMDT   = 8'h08;
  localparam logic [7:0] OFF_GNUM   = 8'h0c;
  localparam logic [7:0] OFF_GDEN   = 8'h10;
  localparam logic [7:0] OFF_PACKED = 8'h14;
  localparam logic [7:0] OFF_STAT   = 8'h18;
  localparam logic [7:0] OFF_MASK   = 8'h1c;
  localparam logic [7:0] OFF_MENU   = 8'h20;
  localparam logic [7:0] OFF_STATE  = 8'h24;
  // Save command codes
  localparam logic [7:0] SAVE_ONLY   = 8'h01;
  localparam logic [7:0] SAVE_REBOOT = 8'h02;
  localparam logic [7:0] REBOOT_ONLY = 8'h03;
  localparam logic [7:0] INIT_CTRL   = 8'h0a;
  // Command type codes (rightmost digit)
  localparam logic [3:0] CT_DUAL  = 4'h0;
  localparam logic [3:0] CT_PDIR  = 4'h1;
  localparam logic [3:0] CT_AB    = 4'h2;
  localparam logic [3:0] CT_COMM  = 4'h8;
  // Reset values, fault display code and hex display limit
  localparam logic [3:0]  CMDT_RST   = 4'h1;
  localparam logic [31:0] GEAR_RST   = 32'h0000_03e8;
  localparam logic [15:0] PACKED_RST = 16'h1001;
  localparam logic [15:0] MOTOR_NONE = 16'h0000;
  localparam logic [15:0] DISP_NONE  = 16'hffff;
  localparam logic [15:0] FAULT_CODE = 16'h4002;
  localparam logic [7:0]  MODE_PULSE = 8'hfc;
  localparam logic [31:0] HEX_LIMIT  = 32'd9999;
  // Status bit positions
  localparam int ST_TIMEOUT = 0;
  localparam int ST_SAVED   = 1;
  localparam int ST_MFAULT  = 2;
  localparam int ST_MLEARN  = 3;
  localparam int ST_W       = 4;
  // Menu inactivity time
  localparam longint CLK_HZ     = 10_000_000;
  localparam longint IDLE_S     = 30;
  localparam longint IDLE_CYC   = IDLE_S * CLK_HZ;
  typedef enum logic [1:0] {
    QPS_IDLE   = 2'b00,
    QPS_SAVE   = 2'b01,
    QPS_REBOOT = 2'b10
  } qps_cmd_t;
endpackage

//--- rtl/qps_idle_timer.sv
`timescale 1ns/100ps
`default_nettype none
module qps_idle_timer
  import qps_pkg::*;
#(
  parameter logic [31:0] LIMIT = 32'd300000000
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  input  wire logic kick,
  output logic      expire
);
  logic [31:0] cnt_r;

  // Counts idle cycles while running; kick restarts the wait
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r  <= 32'h0;
      expire <= 1'b0;
    end
    else
    begin
      expire <= 1'b0;
      if (!run || kick)
        cnt_r <= 32'h0;
      else if (cnt_r == LIMIT - 32'h1)
      begin
        cnt_r  <= 32'h0;
        expire <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 32'h1;
    end
  end
endmodule
`default_nettype wire

//--- rtl/qps_param_store.sv
`timescale 1ns/100ps
`default_nettype none
module qps_param_store
  import qps_pkg::*;
#(
  parameter logic [31:0] IDLE_LIMIT = 32'(IDLE_CYC)
)(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        panelKey,
  input  wire logic        pulseIn,
  input  wire logic        motorIdValid,
  input  wire logic [15:0] motorIdCode,
  input  wire logic [7:1]  din,
  input  wire logic        driveReady,
  input  wire logic        brakeRelease,
  input  wire logic        posReached,
  input  wire logic        zeroSpeed,
  input  wire logic        driveError,
  output logic             scaledStep,
  output logic [7:0]       workMode,
  output logic [6:0]       inFunc,
  output logic [4:1]       dout,
  output logic             alarmOut,
  output logic [7:0]       loopProfile,
  output logic [15:0]      dispCode,
  output logic             dispFlash,
  output logic [1:0]       dispHex,
  output logic             saveReq,
  output logic             rebootReq,
  output logic             irq
);
  logic [3:0]      cmdType_r;
  logic [7:0]      commMode_r;
  logic [31:0]     gearNum_r, gearDen_r;
  logic [15:0]     packed_r, motor_r;
  logic [3:0]      svCmdType_r;
  logic [31:0]     svNum_r, svDen_r;
  logic [15:0]     svPacked_r;
  logic [ST_W-1:0] stat_r, mask_r, evt;
  logic            menuOn_r, chainBoot_r;
  logic [7:0]      menuPos_r;
  logic            motorFault_r;
  logic [32:0]     acc_r;
  qps_cmd_t        cmd_r;
  logic            wrEn, hit, pulseType, idleExp;

  // No wait state: pready is high in the first access cycle
  assign wrEn = psel & penable & pready & pwrite;
  assign pulseType = cmdType_r inside {CT_DUAL, CT_PDIR, CT_AB};
  assign hit = paddr inside {OFF_SAVE, OFF_MOTOR, OFF_CMDT, OFF_GNUM,
                             OFF_GDEN, OFF_PACKED, OFF_STAT, OFF_MASK,
                             OFF_MENU, OFF_STATE};
  // APB handshake and read data
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit;
      if (psel & ~penable & ~pwrite)
        unique case (paddr)
          OFF_MOTOR:  prdata <= {16'h0, motor_r};
          OFF_CMDT:   prdata <= {16'h0, commMode_r, 4'h0, cmdType_r};
          OFF_GNUM:   prdata <= gearNum_r;
          OFF_GDEN:   prdata <= gearDen_r;
          OFF_PACKED: prdata <= {16'h0, packed_r};
          OFF_STAT:   prdata <= {28'h0, stat_r};
          OFF_MASK:   prdata <= {28'h0, mask_r};
          OFF_MENU:   prdata <= {23'h0, menuOn_r, menuPos_r};
          OFF_STATE:  prdata <= {7'h0, motorFault_r, dispCode, workMode};
          default:    prdata <= 32'h0;
        endcase
    end
  end
  // Working values act at once; saved copies survive reboot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmdType_r  <= CMDT_RST;
      commMode_r <= 8'h0;
      gearNum_r  <= GEAR_RST;
      gearDen_r  <= GEAR_RST;
      packed_r   <= PACKED_RST;
    end
    else if (cmd_r == QPS_REBOOT)
    begin
      cmdType_r <= svCmdType_r;
      gearNum_r <= svNum_r;
      gearDen_r <= svDen_r;
      packed_r  <= svPacked_r;
    end
    else if (wrEn && paddr == OFF_SAVE && pwdata[7:0] == INIT_CTRL)
    begin
      cmdType_r <= CMDT_RST;
      gearNum_r <= GEAR_RST;
      gearDen_r <= GEAR_RST;
      packed_r  <= PACKED_RST;
    end
    else if (wrEn)
      unique case (paddr)
        OFF_CMDT:
        begin
          cmdType_r  <= pwdata[3:0];
          commMode_r <= pwdata[15:8];
        end
        OFF_GNUM:   gearNum_r <= pwdata;
        OFF_GDEN:   gearDen_r <= pwdata;
        OFF_PACKED: packed_r  <= pwdata[15:0];
        default:    ;
      endcase
  end
  // Saved copies stand in for non-volatile storage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      svCmdType_r <= CMDT_RST;
      svNum_r     <= GEAR_RST;
      svDen_r     <= GEAR_RST;
      svPacked_r  <= PACKED_RST;
    end
    else if (cmd_r == QPS_SAVE)
    begin
      svCmdType_r <= cmdType_r;
      svNum_r     <= gearNum_r;
      svDen_r     <= gearDen_r;
      svPacked_r  <= packed_r;
    end
  end
  // Save command decode; save runs before a following reboot
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_r     <= QPS_IDLE;
      saveReq   <= 1'b0;
      rebootReq <= 1'b0;
      chainBoot_r <= 1'b0;
    end
    else
    begin
      saveReq   <= cmd_r == QPS_SAVE;
      rebootReq <= cmd_r == QPS_REBOOT;
      if (wrEn && paddr == OFF_SAVE)
      begin
        chainBoot_r <= pwdata[7:0] == SAVE_REBOOT;
        unique case (pwdata[7:0])
          SAVE_ONLY, SAVE_REBOOT: cmd_r <= QPS_SAVE;
          REBOOT_ONLY:            cmd_r <= QPS_REBOOT;
          default:                cmd_r <= QPS_IDLE;
        endcase
      end
      else if (cmd_r == QPS_SAVE && chainBoot_r)
        cmd_r <= QPS_REBOOT;
      else
        cmd_r <= QPS_IDLE;
    end
  end
  // Loop profile recomputed only when a save completes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      loopProfile <= PACKED_RST[7:0];
    else if (saveReq)
      loopProfile <= {svPacked_r[7:4], svPacked_r[3:0]};
  end
  // Setup menu: operator keys keep it alive
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      menuOn_r  <= 1'b0;
      menuPos_r <= 8'h0;
    end
    else if (idleExp)
    begin
      menuOn_r  <= 1'b0;
      menuPos_r <= 8'h0;
    end
    else if (wrEn && paddr == OFF_MENU)
    begin
      menuOn_r  <= pwdata[8];
      menuPos_r <= pwdata[7:0];
    end
    else if (panelKey)
      menuOn_r <= 1'b1;
  end
  qps_idle_timer #(
    .LIMIT (IDLE_LIMIT)
  ) u_idle (
    .clk    (clk),
    .rst_n  (rst_n),
    .run    (menuOn_r),
    .kick   (panelKey | (wrEn && paddr == OFF_MENU)),
    .expire (idleExp)
  );
  // Motor recognition: learn when none held, else compare
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      motor_r      <= MOTOR_NONE;
      motorFault_r <= 1'b0;
    end
    else if (motorIdValid)
      if (motor_r == MOTOR_NONE)
        motor_r <= motorIdCode;
      else if (motorIdCode != motor_r)
        motorFault_r <= 1'b1;
      else
        motorFault_r <= 1'b0;
  end
  // Display code and flashing
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dispCode  <= DISP_NONE;
      dispFlash <= 1'b1;
      dispHex   <= 2'b00;
    end
    else
    begin
      dispFlash <= (motor_r == MOTOR_NONE) | motorFault_r;
      dispCode  <= motorFault_r ? FAULT_CODE :
                   (motor_r == MOTOR_NONE) ? DISP_NONE : motor_r;
      dispHex   <= {gearDen_r > HEX_LIMIT, gearNum_r > HEX_LIMIT};
    end
  end
  // Gear scaler: one step out per cycle while credit covers den
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r      <= 33'h0;
      scaledStep <= 1'b0;
    end
    else if (!pulseType || gearDen_r == 32'h0)
    begin
      acc_r      <= 33'h0;
      scaledStep <= 1'b0;
    end
    else
    begin
      scaledStep <= acc_r >= {1'b0, gearDen_r};
      acc_r <= acc_r + (pulseIn ? {1'b0, gearNum_r} : 33'h0)
             - ((acc_r >= {1'b0, gearDen_r}) ? {1'b0, gearDen_r} : 33'h0);
    end
  end

  // Mode, input and output function mapping
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      workMode <= MODE_PULSE;
      inFunc   <= 7'h0;
      dout     <= 4'h0;
      alarmOut <= 1'b0;
    end
    else
    begin
      workMode  <= pulseType ? MODE_PULSE : commMode_r;
      inFunc[0] <= pulseType & din[1];
      inFunc[1] <= pulseType & din[2];
      inFunc[2] <= pulseType & din[3];
      inFunc[3] <= din[4] & ~packed_r[8];
      inFunc[4] <= din[5] & ~packed_r[8];
      inFunc[5] <= din[7];
      inFunc[6] <= 1'b0;
      dout      <= {zeroSpeed, posReached, brakeRelease, driveReady};
      alarmOut  <= packed_r[12] ? driveError : ~driveError;
    end
  end

  // Sticky events; set wins over write-one clear
  assign evt = {motorIdValid & motor_r == MOTOR_NONE,
                motorIdValid & motor_r != MOTOR_NONE & motorIdCode != motor_r,
                saveReq, idleExp};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stat_r <= '0;
      mask_r <= '0;
      irq    <= 1'b0;
    end
    else
    begin
      stat_r <= (stat_r & ~((wrEn && paddr == OFF_STAT) ?
                pwdata[ST_W-1:0] : '0)) | evt;
      if (wrEn && paddr == OFF_MASK)
        mask_r <= pwdata[ST_W-1:0];
      irq <= |(stat_r & mask_r);
    end
  end

  // Checks
  idle_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    idleExp |=> !menuOn_r && menuPos_r == 8'h0)
    else $error("menu not left on timeout");
  save_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmd_r == QPS_SAVE |=> svPacked_r == $past(packed_r))
    else $error("save did not copy");
  save_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && paddr == OFF_SAVE && pwdata[7:0] == REBOOT_ONLY |=> ##1 rebootReq)
    else $error("reboot not issued");
  chain_boot_a: assert property (@(posedge clk) disable iff (!rst_n)
    wrEn && paddr == OFF_SAVE && pwdata[7:0] == SAVE_REBOOT |=> ##2 rebootReq)
    else $error("save and reboot not chained");
  loop_update_a: assert property (@(posedge clk) disable iff (!rst_n)
    saveReq |=> loopProfile == $past(svPacked_r[7:0]))
    else $error("loop profile stale");
  mode_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    cmdType_r == CT_COMM ##1 cmdType_r == CT_COMM |-> inFunc[2:0] == 3'h0)
    else $error("comm type kept inputs");
  gear_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    !pulseType ##1 !pulseType |-> !scaledStep)
    else $error("scaling outside pulse types");
  alarm_pol_a: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(packed_r[12]) |=> alarmOut == ($past(packed_r[12]) ~^
                                           $past(driveError)))
    else $error("alarm polarity wrong");
  motor_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    motorIdValid && motor_r != MOTOR_NONE && motorIdCode != motor_r
    |=> motorFault_r ##1 dispFlash)
    else $error("mismatch not flagged");
  irq_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    |(stat_r & mask_r) |=> irq)
    else $error("interrupt missing");
  save_cov_c: cover property (@(posedge clk) disable iff (!rst_n) saveReq);
  idle_cov_c: cover property (@(posedge clk) disable iff (!rst_n) idleExp);
  step_cov_c: cover property (@(posedge clk) disable iff (!rst_n)
    scaledStep);
endmodule
`default_nettype wire

//--- test/qps_motion_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module qps_motion_ctrl (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [7:0] count,
  input  wire logic       slow,
  output logic            pulseIn,
  output logic            busy
);
  logic [7:0] left_r;
  logic [2:0] gap_r;

  // Train in progress while pulses remain
  assign busy = (left_r != 8'h00);

  // One-cycle pulses; slow mode spreads them out like a lazy controller
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      left_r  <= 8'h00;
      gap_r   <= 3'h0;
      pulseIn <= 1'b0;
    end
    else if (!busy)
    begin
      left_r  <= go ? count : 8'h00;
      gap_r   <= 3'h0;
      pulseIn <= 1'b0;
    end
    else if (gap_r != 3'h0)
    begin
      gap_r   <= gap_r - 3'h1;
      pulseIn <= 1'b0;
    end
    else
    begin
      left_r  <= left_r - 8'h01;
      gap_r   <= slow ? 3'h5 : 3'h1; // Never back to back
      pulseIn <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- test/qps_param_store_tb.sv
`timescale 1ns/100ps
`default_nettype none
module qps_param_store_tb
  import qps_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        panelKey, pulseIn, motorIdValid, scaledStep, alarmOut;
  logic        driveReady, brakeRelease, posReached, zeroSpeed;
  logic        driveError, dispFlash, saveReq, rebootReq, irq;
  logic        go, slow, busy, err;
  logic [7:0]  paddr, workMode, loopProfile, count;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] motorIdCode, dispCode;
  logic [7:1]  din;
  logic [6:0]  inFunc;
  logic [4:1]  dout;
  logic [1:0]  dispHex;
  int          mismatches, checkCount, saves, reboots, steps;

  // Short idle limit keeps the menu timeout test brief
  qps_param_store #(.IDLE_LIMIT(32'd20)) uut (.clk, .rst_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .panelKey, .pulseIn, .motorIdValid, .motorIdCode, .din, .driveReady,
    .brakeRelease, .posReached, .zeroSpeed, .driveError, .scaledStep,
    .workMode, .inFunc, .dout, .alarmOut, .loopProfile, .dispCode,
    .dispFlash, .dispHex, .saveReq, .rebootReq, .irq);

  qps_motion_ctrl mc (.clk, .rst_n, .go, .count, .slow, .pulseIn, .busy);

  // 10 MHz clock
  always #50 clk = ~clk;

  // Tally one-cycle strobes so none is missed between reads
  always @(posedge clk)
  begin
    if (saveReq === 1'b1) saves++;
    if (rebootReq === 1'b1) reboots++;
    if (scaledStep === 1'b1) steps++;
  end

  task automatic stopTest();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic hang();
    mismatches++;
    stopTest();
  endtask

  task automatic chk(input string n, input logic [31:0] e, g);
    checkCount++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Setup then access; request held until pready is sampled
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (n >= 16) hang();
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk); // Idle edge, so a next call never redrives psel here
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, r);
  endtask

  task automatic pulses(input logic [7:0] k, input logic s);
    int n;
    go <= 1'b1;
    count <= k;
    slow <= s;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy === 1'b1 && n < 200);
    if (n >= 200) hang();
    cyc(8);
  endtask

  task automatic strobe(input logic isKey, input logic [15:0] id);
    panelKey <= isKey;
    motorIdValid <= !isKey;
    motorIdCode <= id;
    @(posedge clk);
    panelKey <= 1'b0;
    motorIdValid <= 1'b0;
    cyc(3);
  endtask

  task automatic tReset();
    rdc(OFF_CMDT, 32'h1);
    rdc(OFF_GNUM, GEAR_RST);
    rdc(OFF_GDEN, GEAR_RST);
    rdc(OFF_PACKED, 32'h1001);
    chk("workMode", MODE_PULSE, workMode);
    chk("dispCode", DISP_NONE, dispCode);
    chk("dispFlash", 1'b1, dispFlash);
    chk("inFunc", 7'h3f, inFunc);
    apb(1'b0, 8'h40, 32'h0);
    chk("pslverr", 1'b1, err);
  endtask

  task automatic tTypes();
    logic [3:0] t [4];
    t = '{CT_DUAL, CT_PDIR, CT_AB, CT_COMM};
    foreach (t[i])
    begin
      wr(OFF_CMDT, {28'h0000050, t[i]});
      cyc(2);
      chk("workMode", t[i] == CT_COMM ? 8'h05 : MODE_PULSE, workMode);
      chk("inFunc", t[i] == CT_COMM ? 7'h38 : 7'h3f, inFunc);
    end
  endtask

  task automatic tGear();
    int s;
    wr(OFF_CMDT, 32'h1);
    wr(OFF_GNUM, 32'h3);
    wr(OFF_GDEN, 32'h2);
    s = steps;
    pulses(8'd4, 1'b0);
    chk("steps", s + 6, steps);
    wr(OFF_CMDT, 32'h0508);
    pulses(8'd4, 1'b1);
    chk("steps", s + 6, steps);
    wr(OFF_GDEN, 32'd9999);
    wr(OFF_GNUM, 32'd10000);
    cyc(2);
    chk("dispHex", 2'b01, dispHex);
  endtask

  task automatic tPacked();
    wr(OFF_CMDT, 32'h1);
    driveError <= 1'b1;
    wr(OFF_PACKED, 32'h1121);
    cyc(2);
    chk("alarmOut", 1'b1, alarmOut);
    chk("inFunc", 7'h27, inFunc);
    chk("loopProfile", 8'h01, loopProfile);
    wr(OFF_PACKED, 32'h0021);
    cyc(2);
    chk("alarmOut", 1'b0, alarmOut);
    chk("inFunc", 7'h3f, inFunc);
  endtask

  task automatic tSave();
    int s;
    int b;
    s = saves;
    b = reboots;
    wr(OFF_PACKED, 32'h1121);
    wr(OFF_SAVE, SAVE_ONLY);
    cyc(4);
    chk("saves", s + 1, saves);
    chk("loopProfile", 8'h21, loopProfile);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("saveDone", 1'b1, r[ST_SAVED]);
    wr(OFF_PACKED, 32'h0);
    wr(OFF_SAVE, REBOOT_ONLY);
    cyc(4);
    chk("reboots", b + 1, reboots);
    rdc(OFF_PACKED, 32'h1121);
    wr(OFF_SAVE, SAVE_REBOOT);
    cyc(8);
    chk("saves", s + 2, saves);
    chk("reboots", b + 2, reboots);
    wr(OFF_SAVE, INIT_CTRL);
    cyc(2);
    rdc(OFF_PACKED, 32'h1001);
    rdc(OFF_GNUM, GEAR_RST);
  endtask

  task automatic tMotor();
    strobe(1'b0, 16'h1234);
    chk("dispCode", 16'h1234, dispCode);
    rdc(OFF_MOTOR, 32'h1234);
    wr(OFF_MASK, 32'h4);
    strobe(1'b0, 16'h5678);
    chk("dispCode", FAULT_CODE, dispCode);
    chk("dispFlash", 1'b1, dispFlash);
    chk("irq", 1'b1, irq);
    wr(OFF_STAT, 32'h4);
    cyc(2);
    chk("irq", 1'b0, irq);
    wr(OFF_MASK, 32'h0);
    wr(OFF_STAT, 32'hf);
  endtask

  task automatic tMenu();
    wr(OFF_MENU, 32'h105);
    cyc(10);
    rdc(OFF_MENU, 32'h105);
    cyc(30);
    rdc(OFF_MENU, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("timeout", 1'b1, r[ST_TIMEOUT]);
    repeat (4)
    begin
      strobe(1'b1, 16'h0);
      cyc(8);
    end
    rdc(OFF_MENU, 32'h100);
  endtask

  task automatic tOut();
    {driveReady, brakeRelease, posReached, zeroSpeed} <= 4'b1010;
    din <= 7'h55;
    cyc(3);
    chk("dout", 4'b0101, dout);
    chk("inFunc", 7'h35, inFunc);
    {driveReady, brakeRelease, posReached, zeroSpeed} <= 4'b0101;
    cyc(3);
    chk("dout", 4'b1010, dout);
  endtask

  // Reset for 8 cycles, then each scenario in turn
  initial
  begin
    {clk, rst_n, psel, penable, pwrite, panelKey, motorIdValid} = '0;
    {go, slow, driveReady, brakeRelease, posReached, zeroSpeed} = '0;
    {driveError, paddr, pwdata, motorIdCode, count} = '0;
    din = 7'h7f; // All inputs active, so the mapping shows in inFunc
    {mismatches, checkCount, saves, reboots, steps} = '0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    tReset();
    tTypes();
    tGear();
    tPacked();
    tSave();
    tMotor();
    tMenu();
    tOut();
    stopTest();
  end
endmodule
`default_nettype wire
